// File: verilog/adc_ctrl_defs.svh
// Offsets, field positions, reset values and timing counts of the A/D control
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

`define ADDR_CONTROL 8'h00
`define ADDR_CONFIG 8'h01
`define ADDR_PINFUNC 8'h02
`define ADDR_RESULT_LO 8'h03
`define ADDR_RESULT_HI 8'h04
`define ADDR_PULLHIGH 8'h05
`define ADDR_DIRECTION 8'h06

`define CTL_START 7
`define CTL_BUSY 6
`define CTL_POWER_OFF 5
`define CTL_CHAN_HI 2
`define CTL_CHAN_LO 0

`define CFG_BANDGAP_SEL 7
`define CFG_BANDGAP_EN 6
`define CFG_REF_SEL 4
`define CFG_DIV_HI 2
`define CFG_DIV_LO 0

`define CONTROL_RST 8'h60
`define CONFIG_RST 8'h00
`define PINFUNC_RST 8'hFF
`define CONTROL_WMASK 8'hA7
`define CONFIG_WMASK 8'hD7

`define CONV_CYCLES 5'h10
`define RESULT_FULL 12'hFFF

`endif

// File: verilog/adc_ctrl_pkg.sv
// Types shared by the A/D control files
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_HELD,
    SEQ_CONVERT,
    SEQ_LOAD
  } seq_state_t;
endpackage

// File: verilog/adc_clk_div.sv
// Divider that makes the A/D clock enable from the system clock
`timescale 1ns/10ps
`default_nettype none
module adc_clk_div (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);
  logic [5:0] cnt_reg;
  logic [5:0] limit;
  logic tick_reg;

  // Code 7 is undefined; treated as the slowest rate
  assign limit = (sel == 3'h7) ? 6'h3F : 6'((7'h01 << sel) - 7'h01);
  assign tick = tick_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 6'h00;
      tick_reg <= 1'b0;
    end else if (!run || cnt_reg >= limit) begin
      cnt_reg <= 6'h00;
      tick_reg <= run;
    end else begin
      cnt_reg <= cnt_reg + 6'h01;
      tick_reg <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verilog/adc_pin_mux.sv
// One shared pin: analog enable overrides pull-high and direction
`timescale 1ns/10ps
`default_nettype none
module adc_pin_mux (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic analog_en,
  input wire logic pullhigh_sw,
  input wire logic dir_input_sw,
  output logic analog_conn,
  output logic pullhigh_on,
  output logic digital_input
);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      analog_conn <= 1'b1;
      pullhigh_on <= 1'b0;
      digital_input <= 1'b1;
    end else begin
      analog_conn <= analog_en; // R12
      pullhigh_on <= pullhigh_sw & ~analog_en; // R13
      digital_input <= dir_input_sw | analog_en; // R14
    end
  end
endmodule
`default_nettype wire

// File: verilog/adc_conversion_control.sv
// Control logic around a 12-bit successive approximation A/D converter
//
// Behaviour
// R1 - Start bit high then low starts conversion
// R2 - Start bit high holds converter reset, busy
// R3 - Busy cleared by hardware when conversion ends
// R4 - End of conversion sets interrupt request flag
// R5 - Software may poll busy flag instead
// R6 - Three-bit divider: 1,2,4..64, code 7 undefined
// R7 - Software keeps A/D clock 0.5us to 10us
// R8 - Power-off bit one switches converter off
// R9 - Software waits settling after power on
// R10 - Software powers converter off when unused
// R11 - Reference select picks external pin, disables others
// R12 - Pin enable bits make pins analog inputs
// R13 - Analog pins lose their pull-high resistors
// R14 - Analog enable overrides port direction setting
// R15 - Bandgap select routes bandgap, drops other channels
// R16 - Result is 12 bits, full scale FFF
// R17 - Channel chosen by bandgap bit and field
// R18 - Result loaded before busy flag clears; the code loads it at the same clock edge that clears busy
// R19 - Sequencer counts fixed A/D clocks per conversion
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_defs.svh"
module adc_conversion_control (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [11:0] sar_result,
  input wire logic [7:0] pullhigh_sw,
  input wire logic [7:0] dir_input_sw,
  output logic sar_reset,
  output logic sar_clk_en,
  output logic sar_power_on,
  output logic bandgap_on,
  output logic [3:0] sar_channel,
  output logic ref_external,
  output logic ref_pin_other_off,
  output logic [7:0] analog_conn,
  output logic [7:0] pullhigh_on,
  output logic [7:0] digital_input,
  output logic int_request
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] control_reg;
  logic [7:0] config_reg;
  logic [7:0] pin_func_reg;
  logic [11:0] result_reg;
  logic [7:0] rdata_reg;
  logic int_request_reg;
  logic sar_reset_reg;
  logic sar_clk_en_reg;
  logic [3:0] sar_channel_reg;
  logic [4:0] count_reg;
  logic [4:0] count_next;
  adc_ctrl_pkg::seq_state_t state_reg;
  adc_ctrl_pkg::seq_state_t state_next;

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  wire wr_control = wr && (addr == `ADDR_CONTROL);
  wire wr_config = wr && (addr == `ADDR_CONFIG);
  wire wr_pinfunc = wr && (addr == `ADDR_PINFUNC);
  wire start_bit = control_reg[`CTL_START];
  wire start_next_val = wr_control ? wdata[`CTL_START] : start_bit;
  wire start_fall = start_bit && !start_next_val; // R1
  wire power_off = control_reg[`CTL_POWER_OFF];
  wire adc_tick;
  wire conv_done = (state_reg == adc_ctrl_pkg::SEQ_LOAD) &&
    (state_next == adc_ctrl_pkg::SEQ_IDLE);
  wire keep_clocking = (state_next == adc_ctrl_pkg::SEQ_CONVERT) ||
    (state_next == adc_ctrl_pkg::SEQ_LOAD);
  wire tick_out = adc_tick && keep_clocking &&
    (state_reg == adc_ctrl_pkg::SEQ_CONVERT);
  wire busy_now = (state_next != adc_ctrl_pkg::SEQ_IDLE);
  wire bandgap_sel = config_reg[`CFG_BANDGAP_SEL];
  wire [2:0] chan_field = control_reg[`CTL_CHAN_HI:`CTL_CHAN_LO];
  wire [7:0] control_rd = control_reg;
  wire [7:0] config_rd = config_reg;
  wire [7:0] result_lo = result_reg[7:0];
  wire [7:0] result_hi = {4'h0, result_reg[11:8]}; // R16

  // ----------------------------------------
  // Clock divider
  // ----------------------------------------
  adc_clk_div u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(state_reg == adc_ctrl_pkg::SEQ_CONVERT),
    .sel(config_reg[`CFG_DIV_HI:`CFG_DIV_LO]), // R6
    .tick(adc_tick)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    unique case (state_reg)
      adc_ctrl_pkg::SEQ_IDLE: begin
        if (start_next_val && !start_bit) begin
          state_next = adc_ctrl_pkg::SEQ_HELD; // R2
        end
      end
      adc_ctrl_pkg::SEQ_HELD: begin
        if (start_fall && !power_off) begin
          state_next = adc_ctrl_pkg::SEQ_CONVERT; // R1
          count_next = 5'h00;
        end else if (start_fall) begin
          state_next = adc_ctrl_pkg::SEQ_IDLE;
        end
      end
      adc_ctrl_pkg::SEQ_CONVERT: begin
        if (start_next_val && !start_bit) begin
          state_next = adc_ctrl_pkg::SEQ_HELD;
        end else if (power_off) begin
          state_next = adc_ctrl_pkg::SEQ_IDLE;
        end else if (adc_tick) begin
          count_next = count_reg + 5'h01;
          if (count_reg == `CONV_CYCLES - 5'h01) begin
            state_next = adc_ctrl_pkg::SEQ_LOAD; // R19
          end
        end
      end
      adc_ctrl_pkg::SEQ_LOAD: begin
        // Extra cycle lets the last converter clock settle the result
        if (start_next_val && !start_bit) begin
          state_next = adc_ctrl_pkg::SEQ_HELD; // R2
        end else if (count_reg == `CONV_CYCLES) begin
          count_next = count_reg + 5'h01;
        end else begin
          state_next = adc_ctrl_pkg::SEQ_IDLE; // R3
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= adc_ctrl_pkg::SEQ_IDLE;
      count_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // ----------------------------------------
  // Register writes and status
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      control_reg <= `CONTROL_RST;
    end else if (wr_control) begin
      control_reg <= (wdata & `CONTROL_WMASK) |
        {1'b0, busy_now, 6'h00};
    end else begin
      control_reg[`CTL_BUSY] <= busy_now; // R2 R3
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      config_reg <= `CONFIG_RST;
    end else if (wr_config) begin
      config_reg <= wdata & `CONFIG_WMASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_func_reg <= `PINFUNC_RST;
    end else if (wr_pinfunc) begin
      pin_func_reg <= wdata;
    end
  end

  // Result loaded in the cycle busy drops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      result_reg <= 12'h000;
    end else if (conv_done) begin
      result_reg <= sar_result & `RESULT_FULL; // R18
    end
  end

  // Read data in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        `ADDR_CONTROL: rdata_reg <= control_rd; // R5
        `ADDR_CONFIG: rdata_reg <= config_rd;
        `ADDR_PINFUNC: rdata_reg <= pin_func_reg;
        `ADDR_RESULT_LO: rdata_reg <= result_lo;
        `ADDR_RESULT_HI: rdata_reg <= result_hi;
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // ----------------------------------------
  // Converter side outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      int_request_reg <= 1'b0;
    end else begin
      int_request_reg <= conv_done; // R4
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sar_reset_reg <= 1'b1;
    end else begin
      sar_reset_reg <= (state_next == adc_ctrl_pkg::SEQ_HELD) ||
        (state_next == adc_ctrl_pkg::SEQ_IDLE); // R2
    end
  end

  // No converter clock in a cycle that aborts the conversion
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sar_clk_en_reg <= 1'b0;
    end else begin
      sar_clk_en_reg <= tick_out; // R19
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sar_channel_reg <= 4'h0;
    end else begin
      sar_channel_reg <= bandgap_sel ? 4'h8 : {1'b0, chan_field}; // R15 R17
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sar_power_on <= 1'b0;
    end else begin
      sar_power_on <= !power_off; // R8
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bandgap_on <= 1'b0;
    end else begin
      bandgap_on <= config_reg[`CFG_BANDGAP_EN];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ref_external <= 1'b0;
    end else begin
      ref_external <= config_reg[`CFG_REF_SEL]; // R11
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ref_pin_other_off <= 1'b0;
    end else begin
      ref_pin_other_off <= config_reg[`CFG_REF_SEL]; // R11
    end
  end

  // ----------------------------------------
  // Shared pins
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_pin
      adc_pin_mux u_pin (
        .ref_clk(ref_clk),
        .rst(rst),
        .analog_en(pin_func_reg[i]), // R12
        .pullhigh_sw(pullhigh_sw[i]),
        .dir_input_sw(dir_input_sw[i]),
        .analog_conn(analog_conn[i]),
        .pullhigh_on(pullhigh_on[i]),
        .digital_input(digital_input[i])
      );
    end
  endgenerate

  assign rdata = rdata_reg;
  assign int_request = int_request_reg;
  assign sar_reset = sar_reset_reg;
  assign sar_clk_en = sar_clk_en_reg;
  assign sar_channel = sar_channel_reg;
endmodule
`default_nettype wire

// File: sim/adc_ctl_chk_sva.sv
// Port relation checker of the A/D control block
`timescale 1ns/10ps
`default_nettype none
module adc_ctl_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic sar_reset,
  input wire logic sar_clk_en,
  input wire logic sar_power_on,
  input wire logic bandgap_on,
  input wire logic [3:0] sar_channel,
  input wire logic ref_external,
  input wire logic ref_pin_other_off,
  input wire logic [7:0] analog_conn,
  input wire logic [7:0] pullhigh_on,
  input wire logic [7:0] digital_input,
  input wire logic int_request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence ctl_wr; wr && addr == 8'h00; endsequence
  sequence cfg_wr; wr && addr == 8'h01; endsequence
  AST_START_HOLD: assert property (ctl_wr ##0 wdata[7] |=> sar_reset)
    else $error("start high did not hold converter reset");
  AST_NO_TICK_IN_RESET: assert property (sar_reset |-> !sar_clk_en)
    else $error("A/D clock ran while converter reset");
  AST_POWER: assert property (ctl_wr |=> ##1
    sar_power_on != $past(wdata[5], 2))
    else $error("power output does not follow power off bit");
  AST_OFF_NO_TICK: assert property (!sar_power_on |-> !sar_clk_en)
    else $error("A/D clock ran while powered off");
  AST_INT_PULSE: assert property (int_request |=> !int_request)
    else $error("interrupt request longer than one cycle");
  AST_BANDGAP: assert property (cfg_wr |=> ##1
    sar_channel[3] == $past(wdata[7], 2) && bandgap_on == $past(wdata[6], 2))
    else $error("bandgap routing does not follow config");
  AST_REF: assert property (cfg_wr |=> ##1
    ref_external == $past(wdata[4], 2))
    else $error("reference select does not follow config");
  AST_REF_OFF: assert property (ref_pin_other_off == ref_external)
    else $error("shared reference pin functions not disabled");
  AST_PULL_OFF: assert property ((pullhigh_on & analog_conn) == 8'h00)
    else $error("pull-high left on an analog pin");
  AST_DIR: assert property ((analog_conn & ~digital_input) == 8'h00)
    else $error("analog pin not forced to input");
  AST_RD_IDLE: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside read answer cycle");
  AST_DONE_IDLE: assert property (int_request |-> sar_reset)
    else $error("converter not back in reset at conversion end");
endmodule
bind adc_conversion_control adc_ctl_chk i_chk (.ref_clk, .rst, .addr,
  .wdata, .wr, .rd, .rdata, .sar_reset, .sar_clk_en, .sar_power_on,
  .bandgap_on, .sar_channel, .ref_external, .ref_pin_other_off,
  .analog_conn, .pullhigh_on, .digital_input, .int_request);
`default_nettype wire

// File: sim/adc_sar_model.sv
// Behavioural converter macro seen behind the control block
`timescale 1ns/10ps
`default_nettype none
module adc_sar_model (
  input wire logic ref_clk,
  input wire logic sar_reset,
  input wire logic sar_clk_en,
  input wire logic sar_power_on,
  input wire logic [3:0] sar_channel,
  output logic [11:0] sar_result
);
  logic [4:0] ticks;
  initial begin
    ticks = 5'h00;
    sar_result = 12'h000;
  end
  // Unsettled result toggles until the sixteenth tick
  always @(posedge ref_clk) begin
    if (sar_reset || !sar_power_on) begin
      ticks <= 5'h00;
      sar_result <= ~sar_result;
    end else if (sar_clk_en && ticks != 5'h10) begin
      ticks <= ticks + 5'h01;
      if (ticks == 5'h0F)
        sar_result <= sar_channel[3] ? 12'hFFF : {sar_channel, 8'hA5};
      else
        sar_result <= ~sar_result;
    end
  end
endmodule
`default_nettype wire

// File: sim/adc_conversion_control_test.sv
// Register level testbench of the A/D control block
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_control_test;
  logic ref_clk, rst, wr, rd, sar_reset, sar_clk_en, sar_power_on;
  logic bandgap_on, ref_external, ref_pin_other_off, int_request, got_int;
  logic [7:0] addr, wdata, rdata, pullhigh_sw, dir_input_sw;
  logic [7:0] analog_conn, pullhigh_on, digital_input;
  logic [11:0] sar_result;
  logic [3:0] sar_channel;
  int mismatches, num_checks, first, last, ticks, n;
  adc_conversion_control i_dut (.ref_clk, .rst, .addr, .wdata, .wr, .rd,
    .rdata, .sar_result, .pullhigh_sw, .dir_input_sw, .sar_reset,
    .sar_clk_en, .sar_power_on, .bandgap_on, .sar_channel, .ref_external,
    .ref_pin_other_off, .analog_conn, .pullhigh_on, .digital_input,
    .int_request);
  adc_sar_model i_sar (.ref_clk, .sar_reset, .sar_clk_en, .sar_power_on,
    .sar_channel, .sar_result);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 check(16'(rdata), 16'(exp));
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ---
  // Main sequence
  // ---
  initial begin
    {rst, wr, rd, addr, wdata, dir_input_sw} = {1'b1, 26'h0};
    pullhigh_sw = 8'hFF;
    mismatches = 0;
    num_checks = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(8'h00, 8'h20);
    rd_reg(8'h01, 8'h00);
    rd_reg(8'h02, 8'hFF);
    rd_reg(8'h07, 8'h00);
    wr_reg(8'h02, 8'h0F);
    repeat (2) @(posedge ref_clk);
    #1 check(16'(analog_conn), 16'h000F);
    check(16'(pullhigh_on), 16'h00F0);
    check(16'(digital_input), 16'h000F);
    wr_reg(8'h01, 8'hD0);
    @(posedge ref_clk);
    #1 check({ref_external, ref_pin_other_off}, 16'h0003);
    check({bandgap_on, sar_channel}, 16'h0018);
    wr_reg(8'h00, 8'hA0);
    wr_reg(8'h00, 8'h20);
    repeat (40) begin
      @(posedge ref_clk);
      #1 check({sar_power_on, int_request}, 16'h0000);
    end
    for (int c = 0; c < 8; c++) begin
      wr_reg(8'h01, {c == 7, c == 7, 3'b000, c[2:0]});
      wr_reg(8'h00, {5'h00, c[2:0]});
      repeat (4) @(posedge ref_clk);
      wr_reg(8'h00, {5'h10, c[2:0]});
      repeat (3) begin
        #1 check({sar_reset, sar_clk_en}, 16'h0002);
        @(posedge ref_clk);
      end
      rd_reg(8'h00, {5'h18, c[2:0]});
      wr_reg(8'h00, {5'h00, c[2:0]});
      check(16'(sar_channel), c == 7 ? 16'h0008 : 16'(c));
      {ticks, got_int, n} = 0;
      while (!got_int && n < 4000) begin
        #1 n++;
        if (sar_clk_en) begin
          if (ticks == 0)
            first = n;
          last = n;
          ticks++;
        end
        got_int = int_request;
        @(posedge ref_clk);
      end
      check(16'(got_int), 16'h0001);
      if (!got_int)
        give_verdict();
      check(16'(ticks), 16'h0010);
      check(16'(last - first), 16'(c == 7 ? 960 : 15 << c));
      rd_reg(8'h00, {5'h00, c[2:0]});
      rd_reg(8'h03, c == 7 ? 8'hFF : 8'hA5);
      rd_reg(8'h04, c == 7 ? 8'h0F : {5'h00, c[2:0]});
    end
    give_verdict();
  end
endmodule
`default_nettype wire
